// file: rtl/oc_cfg_pkg.sv
// Constants for the output conditioning configuration register bank.
// Functional notes
// R1: Filter mode is four bits, bit 4 and bits 2-0; low three reset to 2h.
// R2: Enable clear gives low-pass 2X; set: 1010 low-pass, 1110 high-pass, others forbidden.
// R3: Host sets the decimation control enable when it relies on the filter mode.
// R4: Zone field 000, 001, 010 picks first, second, third zone; others unused.
// R5: Host programs the zone field and sets the zone selection enable.
// R6: Format bit 0: 0 is twos complement, 1 is offset binary.
// R7: Format bit counts only while format enable (bit 5) is set.
// R8: Offset binary only with format enable 1 and format bit set.
// R9: Seven-bit gain code scales output by code/32.
// R10: Gain code acts only while the gain enable bit 0 is set.
// R11: Host writes zero into every reserved bit, gain bit 7 included.
// R12: Filter mode bits steer decimation only while the decimation enable is 1.
// R13: Page settings take effect when the host pulses the reset bit 0-1-0.
// R14: Zone field applies only while the zone enable bit 7 is 1.
// R15: Reads return the last written field value, or its reset value.
package oc_cfg_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PULSE_RESET = 8'h00;
    localparam logic [7:0] IDX_DEC_FILTER = 8'h41;
    localparam logic [7:0] IDX_NYQ_ZONE = 8'h42;
    localparam logic [7:0] IDX_FORMAT_SEL = 8'h43;
    localparam logic [7:0] IDX_GAIN = 8'h44;
    localparam logic [7:0] IDX_FORMAT_EN = 8'h4B;
    localparam logic [7:0] IDX_DEC_EN = 8'h4D;
    localparam logic [7:0] IDX_NYQ_EN = 8'h4E;
    localparam logic [7:0] IDX_GAIN_EN = 8'h52;
    localparam logic [7:0] IDX_STATUS = 8'h80;

    // Field positions.
    localparam int PULSE_BIT = 0;
    localparam int FILTER_HI_BIT = 4;
    localparam int FILTER_LO_LSB = 0;
    localparam int ZONE_LSB = 0;
    localparam int FORMAT_SEL_BIT = 0;
    localparam int GAIN_LSB = 0;
    localparam int GAIN_TOP_BIT = 7;
    localparam int FORMAT_EN_BIT = 5;
    localparam int DEC_EN_BIT = 3;
    localparam int NYQ_EN_BIT = 7;
    localparam int GAIN_EN_BIT = 0;

    // Values after reset.
    localparam logic FILTER_HI_RST = 1'b0;
    localparam logic [2:0] FILTER_LO_RST = 3'h2;
    localparam logic [2:0] ZONE_RST = 3'h0;
    localparam logic [6:0] GAIN_RST = 7'h00;
    localparam logic BIT_RST = 1'b0;

    // Filter mode codes and Nyquist zones.
    localparam logic [3:0] MODE_LOWPASS = 4'hA;
    localparam logic [3:0] MODE_HIGHPASS = 4'hE;
    localparam logic [2:0] ZONE_FIRST = 3'h0;
    localparam logic [2:0] ZONE_SECOND = 3'h1;
    localparam logic [2:0] ZONE_THIRD = 3'h2;

    // Gain arithmetic: the code is divided by 32, so 32 is unity.
    localparam logic [7:0] UNITY_GAIN = 8'h20;
    localparam int GAIN_SHIFT = 5;

    // Bus encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

// file: rtl/output_conditioning_config_regs.sv
// AHB-Lite register bank for the output conditioning settings and its sample path.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module output_conditioning_config_regs
    import oc_cfg_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [15:0] sample_in,
    input wire logic sample_in_valid,
    output logic [15:0] sample_out,
    output logic sample_out_valid,
    output logic filter_highpass_q,
    output logic filter_mode_illegal_q,
    output logic [2:0] nyquist_zone_q,
    output logic nyquist_zone_enabled_q,
    output logic nyquist_zone_illegal_q,
    output logic offset_binary_q,
    output logic [6:0] gain_code_q,
    output logic gain_code_enable_q
);
    // Bus address phase capture.
    logic addr_ok;
    logic take_wr;
    logic take_rd;
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic [31:0] rd_mux;

    // Written (shadow) fields.
    logic pulse_q;
    logic pulse_d;
    logic mode_hi_q;
    logic mode_hi_d;
    logic [2:0] mode_lo_q;
    logic [2:0] mode_lo_d;
    logic [2:0] zone_q;
    logic [2:0] zone_d;
    logic format_sel_q;
    logic format_sel_d;
    logic [7:0] gain_q;
    logic [7:0] gain_d;
    logic format_en_q;
    logic format_en_d;
    logic decimation_control_enable_bit_q;
    logic decimation_control_enable_bit_d;
    logic zone_en_q;
    logic zone_en_d;
    logic gain_en_q;
    logic gain_en_d;

    // Settings in force since the last reset pulse.
    logic apply;
    logic [3:0] mode_act_q;
    logic [2:0] zone_act_q;
    logic format_sel_act_q;
    logic [6:0] gain_act_q;
    logic format_en_act_q;
    logic dec_en_act_q;
    logic zone_en_act_q;
    logic gain_en_act_q;

    assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign take_wr = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
    assign take_rd = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;

    // Zero wait states; every answer is OKAY.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= take_wr && addr_ok;
            if (take_wr)
            begin
                wr_idx_q <= haddr[9:2];
            end
        end
    end

    // Write data lands in the data phase; unmapped indices fall through.
    always_comb
    begin
        pulse_d = pulse_q;
        mode_hi_d = mode_hi_q;
        mode_lo_d = mode_lo_q;
        zone_d = zone_q;
        format_sel_d = format_sel_q;
        gain_d = gain_q;
        format_en_d = format_en_q;
        decimation_control_enable_bit_d = decimation_control_enable_bit_q;
        zone_en_d = zone_en_q;
        gain_en_d = gain_en_q;
        if (wr_pend_q)
        begin
            case (wr_idx_q)
                IDX_PULSE_RESET: pulse_d = hwdata[PULSE_BIT];
                IDX_DEC_FILTER:
                begin
                    mode_hi_d = hwdata[FILTER_HI_BIT]; // R1
                    mode_lo_d = hwdata[FILTER_LO_LSB +: 3]; // R1
                end
                IDX_NYQ_ZONE: zone_d = hwdata[ZONE_LSB +: 3];
                IDX_FORMAT_SEL: format_sel_d = hwdata[FORMAT_SEL_BIT];
                IDX_GAIN: gain_d = hwdata[GAIN_LSB +: 8];
                IDX_FORMAT_EN: format_en_d = hwdata[FORMAT_EN_BIT];
                IDX_DEC_EN: decimation_control_enable_bit_d = hwdata[DEC_EN_BIT];
                IDX_NYQ_EN: zone_en_d = hwdata[NYQ_EN_BIT];
                IDX_GAIN_EN: gain_en_d = hwdata[GAIN_EN_BIT];
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pulse_q <= BIT_RST;
            mode_hi_q <= FILTER_HI_RST; // R1
            mode_lo_q <= FILTER_LO_RST; // R1
            zone_q <= ZONE_RST;
            format_sel_q <= BIT_RST;
            gain_q <= {BIT_RST, GAIN_RST};
            format_en_q <= BIT_RST; // R8
            decimation_control_enable_bit_q <= BIT_RST;
            zone_en_q <= BIT_RST;
            gain_en_q <= BIT_RST;
        end
        else
        begin
            pulse_q <= pulse_d;
            mode_hi_q <= mode_hi_d;
            mode_lo_q <= mode_lo_d;
            zone_q <= zone_d;
            format_sel_q <= format_sel_d;
            gain_q <= gain_d;
            format_en_q <= format_en_d;
            decimation_control_enable_bit_q <= decimation_control_enable_bit_d;
            zone_en_q <= zone_en_d;
            gain_en_q <= gain_en_d;
        end
    end

    // The page settings are taken over when the reset bit returns to 0.
    assign apply = pulse_q && !pulse_d; // R13

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_act_q <= {FILTER_HI_RST, FILTER_LO_RST};
            zone_act_q <= ZONE_RST;
            format_sel_act_q <= BIT_RST;
            gain_act_q <= GAIN_RST;
            format_en_act_q <= BIT_RST;
            dec_en_act_q <= BIT_RST;
            zone_en_act_q <= BIT_RST;
            gain_en_act_q <= BIT_RST;
        end
        else if (apply) // R13
        begin
            mode_act_q <= {mode_hi_q, mode_lo_q};
            zone_act_q <= zone_q;
            format_sel_act_q <= format_sel_q;
            gain_act_q <= gain_q[GAIN_LSB +: 7];
            format_en_act_q <= format_en_q;
            dec_en_act_q <= decimation_control_enable_bit_q;
            zone_en_act_q <= zone_en_q;
            gain_en_act_q <= gain_en_q;
        end
    end

    // Decoded controls for the processing chain.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            filter_highpass_q <= 1'b0;
            filter_mode_illegal_q <= 1'b0;
        end
        else
        begin
            // With the enable clear the default low-pass 2X mode stands.
            filter_highpass_q <= dec_en_act_q && mode_act_q == MODE_HIGHPASS; // R2 R12
            filter_mode_illegal_q <= dec_en_act_q && mode_act_q != MODE_HIGHPASS
                && mode_act_q != MODE_LOWPASS; // R2 R12
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            nyquist_zone_q <= ZONE_FIRST;
            nyquist_zone_enabled_q <= 1'b0;
            nyquist_zone_illegal_q <= 1'b0;
        end
        else
        begin
            nyquist_zone_enabled_q <= zone_en_act_q; // R14
            nyquist_zone_q <= zone_en_act_q ? zone_act_q : ZONE_FIRST; // R4 R14
            nyquist_zone_illegal_q <= zone_en_act_q && zone_act_q != ZONE_FIRST
                && zone_act_q != ZONE_SECOND && zone_act_q != ZONE_THIRD; // R4
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            offset_binary_q <= 1'b0;
            gain_code_q <= GAIN_RST;
            gain_code_enable_q <= 1'b0;
        end
        else
        begin
            offset_binary_q <= format_en_act_q && format_sel_act_q; // R6 R7 R8
            gain_code_q <= gain_act_q;
            gain_code_enable_q <= gain_en_act_q; // R10
        end
    end

    sample_conditioner u_cond (
        .clk(hclk),
        .rst_n(hresetn),
        .sample_in(sample_in),
        .sample_in_valid(sample_in_valid),
        .gain_code(gain_code_q),
        .gain_en(gain_code_enable_q),
        .offset_binary(offset_binary_q),
        .sample_out(sample_out),
        .sample_out_valid(sample_out_valid)
    );

    // Reads use the next values so a read right behind a write sees it.
    always_comb
    begin
        rd_mux = 32'h00000000;
        if (addr_ok)
        begin
            case (haddr[9:2])
                IDX_PULSE_RESET: rd_mux[PULSE_BIT] = pulse_d; // R15
                IDX_DEC_FILTER:
                begin
                    rd_mux[FILTER_HI_BIT] = mode_hi_d; // R15
                    rd_mux[FILTER_LO_LSB +: 3] = mode_lo_d;
                end
                IDX_NYQ_ZONE: rd_mux[ZONE_LSB +: 3] = zone_d;
                IDX_FORMAT_SEL: rd_mux[FORMAT_SEL_BIT] = format_sel_d;
                IDX_GAIN: rd_mux[GAIN_LSB +: 8] = gain_d;
                IDX_FORMAT_EN: rd_mux[FORMAT_EN_BIT] = format_en_d;
                IDX_DEC_EN: rd_mux[DEC_EN_BIT] = decimation_control_enable_bit_d;
                IDX_NYQ_EN: rd_mux[NYQ_EN_BIT] = zone_en_d;
                IDX_GAIN_EN: rd_mux[GAIN_EN_BIT] = gain_en_d;
                IDX_STATUS:
                begin
                    rd_mux[0] = filter_highpass_q;
                    rd_mux[1] = filter_mode_illegal_q;
                    rd_mux[4:2] = nyquist_zone_q;
                    rd_mux[5] = nyquist_zone_enabled_q;
                    rd_mux[6] = nyquist_zone_illegal_q;
                    rd_mux[7] = offset_binary_q;
                    rd_mux[14:8] = gain_code_q;
                    rd_mux[15] = gain_code_enable_q;
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else if (take_rd)
        begin
            hrdata <= rd_mux; // R15
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence gain_write_s;
        wr_pend_q && wr_idx_q == IDX_GAIN ##1 !wr_pend_q;
    endsequence

    sequence pulse_fall_s;
        pulse_q ##1 !pulse_q;
    endsequence

    apply_on_pulse_a: assert property (pulse_fall_s |-> // R13
        dec_en_act_q == $past(decimation_control_enable_bit_q)
        && mode_act_q == {$past(mode_hi_q), $past(mode_lo_q)})
    else $error("Settings were not taken over at the end of the pulse.");

    hold_no_pulse_a: assert property (!apply |=> $stable(mode_act_q) && $stable(gain_en_act_q)) // R13
    else $error("Settings changed without a reset pulse.");

    highpass_decode_a: assert property (dec_en_act_q && mode_act_q == MODE_HIGHPASS |=> // R2
        filter_highpass_q && !filter_mode_illegal_q)
    else $error("High-pass code not decoded.");

    default_mode_a: assert property (!dec_en_act_q |=> // R12
        !filter_highpass_q && !filter_mode_illegal_q)
    else $error("Filter mode acted while decimation control was off.");

    zone_gate_a: assert property (!zone_en_act_q |=> nyquist_zone_q == ZONE_FIRST // R14
        && !nyquist_zone_illegal_q)
    else $error("Zone applied while zone selection was off.");

    zone_unused_a: assert property (zone_en_act_q && zone_act_q == 3'h5 |=> // R4
        nyquist_zone_illegal_q ##1 (nyquist_zone_illegal_q || !$past(zone_en_act_q)
        || $past(zone_act_q) != 3'h5))
    else $error("Unused zone code not flagged.");

    format_gate_a: assert property (!format_en_act_q |=> !offset_binary_q) // R7
    else $error("Offset binary without format enable.");

    format_set_a: assert property (format_en_act_q && format_sel_act_q |=> offset_binary_q) // R8
    else $error("Offset binary not selected.");

    readback_a: assert property (gain_write_s ##1 take_rd && addr_ok // R15
        && haddr[9:2] == IDX_GAIN && !wr_pend_q |=> hrdata[7:0] == $past(gain_q))
    else $error("Gain readback differs from written value.");
endmodule // output_conditioning_config_regs

// file: rtl/sample_conditioner.sv
// Sample path that applies the digital gain and the output number format.
`timescale 1ns/1ps
module sample_conditioner
    import oc_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] sample_in,
    input wire logic sample_in_valid,
    input wire logic [6:0] gain_code,
    input wire logic gain_en,
    input wire logic offset_binary,
    output logic [15:0] sample_out,
    output logic sample_out_valid
);
    logic [7:0] mult;
    logic signed [23:0] prod;
    logic signed [23:0] scaled;
    logic [15:0] sat;

    always_comb
    begin
        mult = gain_en ? {1'b0, gain_code} : UNITY_GAIN; // R10
        prod = $signed(sample_in) * $signed(mult); // R9
        scaled = prod >>> GAIN_SHIFT; // R9
        // Large codes can push a full-scale sample past 16 bits, so clip.
        if (scaled[23:15] == 9'h000 || scaled[23:15] == 9'h1FF)
        begin
            sat = scaled[15:0];
        end
        else
        begin
            sat = scaled[23] ? 16'h8000 : 16'h7FFF;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample_out <= 16'h0000;
            sample_out_valid <= 1'b0;
        end
        else
        begin
            sample_out_valid <= sample_in_valid;
            if (sample_in_valid)
            begin
                sample_out <= {sat[15] ^ offset_binary, sat[14:0]}; // R6
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    gain_bypass_a: assert property (sample_in_valid && !gain_en && !offset_binary |=> // R10
        sample_out == $past(sample_in))
    else $error("Sample changed while gain and format were off.");

    format_flip_a: assert property (sample_in_valid && !gain_en && offset_binary |=> // R6
        sample_out == {~$past(sample_in[15]), $past(sample_in[14:0])})
    else $error("Offset binary output did not invert the sign bit.");
endmodule // sample_conditioner

// file: verification/test_output_conditioning_config_regs.sv
// Self-checking testbench for the output conditioning configuration register bank.
`timescale 1ns/1ps
module test_output_conditioning_config_regs;
    import oc_cfg_pkg::*;
    localparam int TIMEOUT_CYCLES = 20000;
    localparam logic [7:0] IDX_UNMAPPED = 8'h10;
    logic hclk = 1'b0;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [15:0] sample_in;
    logic sample_in_valid;
    logic [15:0] sample_out;
    logic sample_out_valid;
    logic filter_highpass_q;
    logic filter_mode_illegal_q;
    logic [2:0] nyquist_zone_q;
    logic nyquist_zone_enabled_q;
    logic nyquist_zone_illegal_q;
    logic offset_binary_q;
    logic [6:0] gain_code_q;
    logic gain_code_enable_q;
    wire logic [15:0] pins;
    integer seed = 32'hD3DE03BA;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] e_stat = 16'h0000;
    logic [7:0] idx_tbl [9] = '{IDX_PULSE_RESET, IDX_DEC_FILTER, IDX_NYQ_ZONE, IDX_FORMAT_SEL,
        IDX_GAIN, IDX_FORMAT_EN, IDX_DEC_EN, IDX_NYQ_EN, IDX_GAIN_EN};
    logic [7:0] mask_tbl [9] = '{8'h01, 8'h17, 8'h07, 8'h01, 8'h7F, 8'h20, 8'h08, 8'h80, 8'h01};
    logic [3:0] mode_tbl [4] = '{MODE_LOWPASS, MODE_HIGHPASS, 4'h2, 4'hF};

    // The decoded outputs laid out like the status word, so one expectation serves both.
    assign pins = {gain_code_enable_q, gain_code_q, offset_binary_q, nyquist_zone_illegal_q,
        nyquist_zone_enabled_q, nyquist_zone_q, filter_mode_illegal_q, filter_highpass_q};
    assign hready = hreadyout;

    output_conditioning_config_regs u_output_conditioning_config_regs (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_in(sample_in),
        .sample_in_valid(sample_in_valid), .sample_out(sample_out),
        .sample_out_valid(sample_out_valid), .filter_highpass_q(filter_highpass_q),
        .filter_mode_illegal_q(filter_mode_illegal_q), .nyquist_zone_q(nyquist_zone_q),
        .nyquist_zone_enabled_q(nyquist_zone_enabled_q),
        .nyquist_zone_illegal_q(nyquist_zone_illegal_q), .offset_binary_q(offset_binary_q),
        .gain_code_q(gain_code_q), .gain_code_enable_q(gain_code_enable_q)
    );

    always #12.5 hclk = ~hclk;

    task automatic end_of_test();
        $display("comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single word transfer; the address phase is held until hready is seen high.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, idx, d, unused);
    endtask

    task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, idx, 32'h00000000, got);
        check(got, exp);
    endtask

    function automatic logic [15:0] status_of(input logic [3:0] mode, input logic dec_en,
        input logic [2:0] zone, input logic zen, input logic fsel, input logic fen,
        input logic [6:0] gain, input logic gen);
        logic [15:0] s;
        s[0] = dec_en && mode == MODE_HIGHPASS;
        s[1] = dec_en && mode != MODE_LOWPASS && mode != MODE_HIGHPASS;
        s[4:2] = zen ? zone : ZONE_FIRST;
        s[5] = zen;
        s[6] = zen && zone > ZONE_THIRD;
        s[7] = fen && fsel;
        s[14:8] = gain;
        s[15] = gen;
        return s;
    endfunction

    // Gain of code/32 (unity when disabled), saturation, then the sign flip for offset binary.
    function automatic logic [15:0] cond(input logic [15:0] s, input logic [15:0] st);
        logic signed [31:0] p;
        logic signed [8:0] g;
        g = st[15] ? $signed({2'b00, st[14:8]}) : $signed({1'b0, UNITY_GAIN});
        p = $signed(s) * g;
        p = p >>> GAIN_SHIFT;
        if (p > 32767)
            p = 32767;
        else if (p < -32768)
            p = -32768;
        return p[15:0] ^ {st[7], 15'h0000};
    endfunction

    task automatic send_sample(input logic [15:0] s);
        @(posedge hclk);
        sample_in <= s;
        sample_in_valid <= 1'b1;
        @(posedge hclk);
        sample_in_valid <= 1'b0;
        #1;
        check({31'h0, sample_out_valid}, 32'h1);
        check({16'h0, sample_out}, {16'h0, cond(s, e_stat)});
    endtask

    task automatic apply_cfg(input logic [3:0] mode, input logic dec_en, input logic [2:0] zone,
        input logic zen, input logic fsel, input logic fen, input logic [6:0] gain,
        input logic gen);
        wr(IDX_DEC_FILTER, {27'h0, mode[3], 1'b0, mode[2:0]});
        wr(IDX_DEC_EN, {28'h0, dec_en, 3'h0});
        wr(IDX_NYQ_ZONE, {29'h0, zone});
        wr(IDX_NYQ_EN, {24'h0, zen, 7'h00});
        wr(IDX_FORMAT_SEL, {31'h0, fsel});
        wr(IDX_FORMAT_EN, {26'h0, fen, 5'h00});
        wr(IDX_GAIN, {25'h0, gain});
        wr(IDX_GAIN_EN, {31'h0, gen});
        #1;
        check({16'h0, pins}, {16'h0, e_stat});
        wr(IDX_PULSE_RESET, 32'h1);
        rd_check(IDX_PULSE_RESET, 32'h1);
        wr(IDX_PULSE_RESET, 32'h0);
        e_stat = status_of(mode, dec_en, zone, zen, fsel, fen, gain, gen);
        repeat (3) @(posedge hclk);
        #1;
        check({16'h0, pins}, {16'h0, e_stat});
        rd_check(IDX_STATUS, {16'h0, e_stat});
        rd_check(IDX_DEC_FILTER, {27'h0, mode[3], 1'b0, mode[2:0]});
    endtask

    initial
    begin
        logic [31:0] d;
        logic [31:0] r;
        logic [6:0] gain;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        sample_in = 16'h0000;
        sample_in_valid = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        check({16'h0, pins}, 32'h0);
        for (int i = 0; i < 9; i++)
            rd_check(idx_tbl[i], i == 1 ? {29'h0, FILTER_LO_RST} : 32'h0);
        wr(IDX_UNMAPPED, 32'hFFFFFFFF);
        rd_check(IDX_UNMAPPED, 32'h0);
        wr(IDX_STATUS, 32'h0000FFFF);
        rd_check(IDX_STATUS, 32'h0);
        repeat (3)
            for (int i = 1; i < 9; i++)
            begin
                d = $random(seed) & {24'h0, mask_tbl[i]};
                wr(idx_tbl[i], d);
                rd_check(idx_tbl[i], d);
            end
        for (int k = 0; k < 32; k++)
        begin
            r = $random(seed);
            if (k < 8)
            begin
                gain = k == 0 ? 7'h7F : (k == 1 ? 7'h00 : 7'h20);
                apply_cfg(mode_tbl[k % 4], 1'b1, k[2:0], 1'b1, k[0], 1'b1, gain, 1'b1);
            end
            else
                apply_cfg(r[0] ? mode_tbl[r[2:1]] : r[6:3], r[7], r[10:8], r[11], r[12], r[13],
                    r[20:14], r[21]);
            send_sample(16'h7FFF);
            send_sample(16'h8000);
            send_sample(16'h0000);
            send_sample(r[31:16]);
        end
        end_of_test();
    end
endmodule // test_output_conditioning_config_regs
